/* src/dtmf_out_defs.vh */
`ifndef DTMF_OUT_DEFS_VH
`define DTMF_OUT_DEFS_VH

// clock and timing
`define CLK_PERIOD_NS      4
`define TONE_DEADLINE_NS   40000000
`define TONE_DEADLINE_CYC  (`TONE_DEADLINE_NS / `CLK_PERIOD_NS)
`define STROBE_DELAY_NS    7000
`define STROBE_DELAY_CYC   ((`STROBE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TB_DIVIDE          8

// register byte offsets
`define REG_CTRL           8'h00
`define REG_STATUS         8'h04
`define REG_INT_STAT       8'h08
`define REG_INT_MASK       8'h0C
`define REG_TB_COUNT       8'h10

// control fields and reset value
`define CTRL_HEX_BIT       0
`define CTRL_OE_BIT        1
`define CTRL_RESET         2'h3

// status fields
`define STAT_CODE_LSB      0
`define STAT_STROBE_BIT    4
`define STAT_TONE_BIT      5

// interrupt fields
`define INT_DIGIT_BIT      0
`define INT_PAUSE_BIT      1

// axi responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

/* src/timebase_div.v */
`timescale 1ns/1ps
`include "dtmf_out_defs.vh"

module timebase_div
(
	// clock and reset
	input  wire aclk,
	input  wire aresetn,
	// oscillator pins
	input  wire oscillator_select,
	input  wire crystal_input,
	output reg  crystal_output,
	// alternate time base pin
	input  wire atb_in,
	output reg  atb_out,
	output reg  atb_oe,
	// time base event
	output reg  tb_tick
);

	localparam integer HALF_FULL = (`TB_DIVIDE / 2) - 1;
	localparam [1:0]   HALF_LIM  = HALF_FULL[1:0];

	reg       xin_prev_q;
	reg       atb_prev_q;
	reg [1:0] div_q;
	wire      xin_rise;
	wire      atb_rise;

	assign xin_rise = crystal_input & ~xin_prev_q;
	assign atb_rise = atb_in & ~atb_prev_q;

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			xin_prev_q     <= 1'b0;
			atb_prev_q     <= 1'b0;
			div_q          <= 2'h0;
			atb_out        <= 1'b0;
			atb_oe         <= 1'b0;
			tb_tick        <= 1'b0;
			crystal_output <= 1'b0;
		end
		else
		begin
			xin_prev_q <= crystal_input;
			atb_prev_q <= atb_in;
			// pin turns into an input while the select is low
			atb_oe     <= oscillator_select;
			// crystal output only feeds the resonator, never other loads
			crystal_output <= oscillator_select & ~crystal_input;
			if (oscillator_select)
			begin
				tb_tick <= xin_rise;
				if (xin_rise)
				begin
					// toggle every four edges gives one eighth
					if (div_q == HALF_LIM)
					begin
						div_q   <= 2'h0;
						atb_out <= ~atb_out;
					end
					else
						div_q <= div_q + 2'h1;
				end
			end
			else
			begin
				// foreign divided clock is the time base
				tb_tick <= atb_rise;
				div_q   <= 2'h0;
				atb_out <= 1'b0;
			end
		end
	end

endmodule

/* src/dtmf_digit_output.v */
`timescale 1ns/1ps
`include "dtmf_out_defs.vh"

module dtmf_digit_output
#(
	parameter DETECT_CYC = `TONE_DEADLINE_CYC
)
(
	// clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// tone detector
	input  wire        tone_pair,
	input  wire [3:0]  key_index,
	// digit port
	output reg         code_bit3,
	output reg         code_bit2,
	output reg         code_bit1,
	output reg         code_bit0,
	output reg         code_oe,
	output reg         tone_valid_strobe,
	input  wire        strobe_clear_input,
	// oscillator pins
	input  wire        oscillator_select,
	input  wire        crystal_input,
	output wire        crystal_output,
	input  wire        atb_in,
	output wire        atb_out,
	output wire        atb_oe,
	// interrupt
	output reg         irq,
	// axi4-lite write address
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// axi4-lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// axi4-lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// axi4-lite read address
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	// axi4-lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);

	localparam integer QUAL_FULL   = DETECT_CYC - 2;
	localparam integer STROBE_FULL = `STROBE_DELAY_CYC - 1;
	localparam [23:0]  QUAL_LIM    = QUAL_FULL[23:0];
	localparam [23:0]  STROBE_LIM  = STROBE_FULL[23:0];

	localparam [4:0] ST_IDLE    = 5'h01;
	localparam [4:0] ST_QUAL    = 5'h02;
	localparam [4:0] ST_SETTLE  = 5'h04;
	localparam [4:0] ST_HOLD    = 5'h08;
	localparam [4:0] ST_CLEARED = 5'h10;

	reg  [4:0]  state_q;
	reg  [23:0] cnt_q;
	reg  [23:0] gap_q;
	reg  [3:0]  key_q;
	reg  [1:0]  ctrl_q;
	reg  [1:0]  int_stat_q;
	reg  [1:0]  int_mask_q;
	reg  [15:0] tb_count_q;
	reg         digit_ev;
	reg         pause_ev;
	reg  [3:0]  hex_code;
	reg         aw_held_q;
	reg  [7:0]  aw_addr_q;
	reg         w_held_q;
	reg  [31:0] w_data_q;
	reg  [3:0]  w_strb_q;
	wire        tb_tick;
	wire        wr_go;
	wire [1:0]  w1c;

	timebase_div u_timebase
	(
		.aclk              (aclk),
		.aresetn           (aresetn),
		.oscillator_select (oscillator_select),
		.crystal_input     (crystal_input),
		.crystal_output    (crystal_output),
		.atb_in            (atb_in),
		.atb_out           (atb_out),
		.atb_oe            (atb_oe),
		.tb_tick           (tb_tick)
	);

	// key order: digits 0-9, star, hash, A, B, C, D
	always @*
	begin
		hex_code = key_index;
		if (ctrl_q[`CTRL_HEX_BIT])
		begin
			case (key_index)
				4'h0:    hex_code = 4'hA;
				4'hA:    hex_code = 4'hB;
				4'hB:    hex_code = 4'hC;
				4'hC:    hex_code = 4'hD;
				4'hD:    hex_code = 4'hE;
				4'hE:    hex_code = 4'hF;
				4'hF:    hex_code = 4'h0; // tone D shares the pause code
				default: hex_code = key_index;
			endcase
		end
	end

	// tone sequencer
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q           <= ST_IDLE;
			cnt_q             <= 24'h000000;
			gap_q             <= 24'h000000;
			key_q             <= 4'h0;
			code_bit3         <= 1'b0;
			code_bit2         <= 1'b0;
			code_bit1         <= 1'b0;
			code_bit0         <= 1'b0;
			tone_valid_strobe <= 1'b0;
			digit_ev          <= 1'b0;
			pause_ev          <= 1'b0;
		end
		else
		begin
			digit_ev <= 1'b0;
			pause_ev <= 1'b0;
			// pause qualification runs while a digit is shown
			if (tone_pair || state_q == ST_IDLE || state_q == ST_QUAL)
				gap_q <= 24'h000000;
			else
				gap_q <= gap_q + 24'h000001;
			case (state_q)
				ST_IDLE:
				begin
					if (tone_pair)
					begin
						state_q <= ST_QUAL;
						cnt_q   <= 24'h000000;
						key_q   <= hex_code;
					end
				end
				ST_QUAL:
				begin
					cnt_q <= cnt_q + 24'h000001;
					if (!tone_pair)
						state_q <= ST_IDLE;
					else if (hex_code != key_q)
					begin
						// a changing pair restarts qualification
						cnt_q <= 24'h000000;
						key_q <= hex_code;
					end
					else if (cnt_q >= QUAL_LIM)
					begin
						// code driven before the deadline
						{code_bit3, code_bit2, code_bit1, code_bit0} <= key_q;
						state_q <= ST_SETTLE;
						cnt_q   <= 24'h000000;
					end
				end
				ST_SETTLE:
				begin
					cnt_q <= cnt_q + 24'h000001;
					if (strobe_clear_input)
						state_q <= ST_CLEARED;
					else if (cnt_q >= STROBE_LIM)
					begin
						// code is already stable when the strobe rises
						tone_valid_strobe <= 1'b1;
						digit_ev          <= 1'b1;
						state_q           <= ST_HOLD;
					end
				end
				ST_HOLD:
				begin
					if (strobe_clear_input)
					begin
						tone_valid_strobe <= 1'b0;
						state_q           <= ST_CLEARED;
					end
					// strobe kept while the pair stays present
				end
				ST_CLEARED:
				begin
					// same tone continuing never re-raises the strobe
					tone_valid_strobe <= 1'b0;
				end
				default:
				begin
					state_q           <= ST_IDLE;
					tone_valid_strobe <= 1'b0;
				end
			endcase
			if ((state_q == ST_SETTLE || state_q == ST_HOLD ||
			     state_q == ST_CLEARED) && !tone_pair && gap_q >= QUAL_LIM)
			begin
				// valid pause clears code and strobe
				{code_bit3, code_bit2, code_bit1, code_bit0} <= 4'h0;
				tone_valid_strobe <= 1'b0;
				pause_ev          <= 1'b1;
				state_q           <= ST_IDLE;
			end
		end
	end

	// axi write path: address and data taken in either order
	assign wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;
	assign w1c   = (wr_go && aw_addr_q == `REG_INT_STAT && w_strb_q[0]) ?
	               w_data_q[1:0] : 2'h0;

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_q     <= 1'b0;
			aw_addr_q     <= 8'h00;
			w_held_q      <= 1'b0;
			w_data_q      <= 32'h00000000;
			w_strb_q      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
			ctrl_q        <= `CTRL_RESET;
			int_mask_q    <= 2'h0;
		end
		else
		begin
			s_axi_awready <= ~aw_held_q & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready  <= ~w_held_q & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wr_go)
			begin
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `RESP_OKAY;
				case (aw_addr_q)
					`REG_CTRL:
						if (w_strb_q[0])
							ctrl_q <= w_data_q[1:0];
					`REG_INT_MASK:
						if (w_strb_q[0])
							int_mask_q <= w_data_q[1:0];
					`REG_STATUS, `REG_INT_STAT, `REG_TB_COUNT:
						s_axi_bresp <= `RESP_OKAY;
					default:
						s_axi_bresp <= `RESP_SLVERR;
				endcase
			end
		end
	end

	// sticky events, interrupt and time base monitor
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			int_stat_q <= 2'h0;
			irq        <= 1'b0;
			tb_count_q <= 16'h0000;
			code_oe    <= 1'b0;
		end
		else
		begin
			// a new event wins over a clear in the same cycle
			int_stat_q <= (int_stat_q & ~w1c) | {pause_ev, digit_ev};
			irq        <= |(int_stat_q & int_mask_q);
			// released code bits leave a shared bus free
			code_oe    <= ctrl_q[`CTRL_OE_BIT];
			if (tb_tick)
				tb_count_q <= tb_count_q + 16'h0001;
		end
	end

	// axi read path
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `RESP_OKAY;
				s_axi_rdata  <= 32'h00000000;
				case (s_axi_araddr)
					`REG_CTRL:
						s_axi_rdata[1:0] <= ctrl_q;
					`REG_STATUS:
						s_axi_rdata[5:0] <= {tone_pair, tone_valid_strobe,
						                     code_bit3, code_bit2,
						                     code_bit1, code_bit0};
					`REG_INT_STAT:
						s_axi_rdata[1:0] <= int_stat_q;
					`REG_INT_MASK:
						s_axi_rdata[1:0] <= int_mask_q;
					`REG_TB_COUNT:
						s_axi_rdata[15:0] <= tb_count_q;
					default:
						s_axi_rresp <= `RESP_SLVERR;
				endcase
			end
		end
	end

endmodule

/* verif/digit_checker_assertions.sv */
`timescale 1ns/1ps
`include "dtmf_out_defs.vh"
module digit_checker
(
	// clock and reset
	input wire	aclk,
	input wire	aresetn,
	// digit port
	input wire	tone_pair,
	input wire	tone_valid_strobe,
	input wire	strobe_clear_input,
	input wire	code_bit3,
	input wire	code_bit2,
	input wire	code_bit1,
	input wire	code_bit0,
	// time base pin
	input wire	oscillator_select,
	input wire	atb_oe
);
	localparam int SMIN = `STROBE_DELAY_CYC - 3;
	wire [3:0]	c = {code_bit3, code_bit2, code_bit1, code_bit0};
	logic [3:0]	c_q;
	logic [15:0]	s_q;
	// age of the code; saturates so a long hold stays legal
	always @(posedge aclk)
		if (!aresetn)
		begin
			c_q <= 4'h0;
			s_q <= 16'h0;
		end
		else
		begin
			c_q <= c;
			s_q <= (c != c_q) ? 16'h0 : s_q + {15'h0, ~&s_q};
		end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	clear_drop_a: assert property (
		strobe_clear_input |=> !tone_valid_strobe)
		else $error("strobe survived a clear");
	code_first_a: assert property (
		$rose(tone_valid_strobe) |-> s_q >= SMIN)
		else $error("strobe rose too soon after code");
	strobe_hold_a: assert property (
		tone_valid_strobe && tone_pair && !strobe_clear_input
		|=> tone_valid_strobe)
		else $error("strobe dropped under a tone");
	code_hold_a: assert property (
		tone_valid_strobe && tone_pair |=> $stable(c))
		else $error("code moved under a tone");
	pause_zero_a: assert property (
		$fell(tone_valid_strobe) && !$past(strobe_clear_input)
		|-> c == 4'h0)
		else $error("pause left code bits set");
	no_repeat_a: assert property (
		$fell(tone_valid_strobe) && tone_pair
		|=> !tone_valid_strobe [*8])
		else $error("strobe came back for same tone");
	sel_low_a: assert property (
		!oscillator_select |=> !atb_oe)
		else $error("time base pin driven as input");
	sel_high_a: assert property (
		aresetn && oscillator_select |=> atb_oe)
		else $error("time base pin not driven");
	cover property ($rose(tone_valid_strobe));
	cover property (strobe_clear_input && tone_valid_strobe);
	cover property ($fell(tone_valid_strobe) && !tone_pair);
endmodule
bind dtmf_digit_output digit_checker i_chk(.aclk, .aresetn, .tone_pair,
	.tone_valid_strobe, .strobe_clear_input, .code_bit3, .code_bit2,
	.code_bit1, .code_bit0, .oscillator_select, .atb_oe);

/* verif/line_monitor.sv */
`timescale 1ns/1ps
module line_monitor
(
	// clock and reset
	input wire		aclk,
	input wire		aresetn,
	// bench control
	input wire		en,
	input wire		slow,
	// digit port
	input wire		tone_valid_strobe,
	input wire [3:0]	code,
	output logic		strobe_clear_input,
	// captured results
	output logic [3:0]	got,
	output wire		pause_seen
);
	logic [7:0]	w_q;
	// after a clear the strobe is gone, so all-zero is the pause sign
	assign pause_seen = ~|code;
	// polled every cycle, far inside the poll limit
	always @(posedge aclk)
		if (!aresetn)
		begin
			strobe_clear_input <= 1'h0;
			w_q <= 8'h00;
			got <= 4'h0;
		end
		else
		begin
			strobe_clear_input <= 1'h0;
			if (en && tone_valid_strobe && !strobe_clear_input)
			begin
				w_q <= w_q + 8'h01;
				if (!slow || w_q == 8'h63)
				begin
					got <= code;
					strobe_clear_input <= 1'h1;
					w_q <= 8'h00;
				end
			end
		end
endmodule

/* verif/dtmf_digit_output_handshake_bench.sv */
`timescale 1ns/1ps
`include "dtmf_out_defs.vh"
module dtmf_digit_output_handshake_bench;
	localparam int DC = 20;
	localparam int SD = `STROBE_DELAY_CYC;
	logic aclk, aresetn, tone_pair, oscillator_select, en, slow, p, xp;
	logic [3:0] key_index;
	logic [7:0] xc = 8'h00;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, rd, r2;
	logic [1:0] rs;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready;
	wire code_bit3, code_bit2, code_bit1, code_bit0, code_oe, irq;
	wire tone_valid_strobe, strobe_clear_input, pause_seen;
	wire atb_out, atb_oe, crystal_input, atb_in, crystal_output;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [3:0] s_axi_wstrb = 4'hF;
	wire [3:0] code = {code_bit3, code_bit2, code_bit1, code_bit0};
	wire [3:0] got;
	int fail_count, total_checks, i, n, q;
	// format, key, expected code
	logic [8:0] rows [9] = '{9'h10A, 9'h155, 9'h1AB, 9'h1BC, 9'h1CD,
		9'h1DE, 9'h1EF, 9'h1F0, 9'h033};
	// unused crystal pin held high when the pin is an input
	assign crystal_input = oscillator_select ? xc[3] : 1'h1;
	assign atb_in = xc[6];
	always @(posedge aclk)
		xc <= xc + 8'h01;
	// crystal output only watched, it drives no other load
	dtmf_digit_output #(.DETECT_CYC(DC)) i_dut(.aclk, .aresetn,
		.tone_pair, .key_index, .code_bit3, .code_bit2, .code_bit1,
		.code_bit0, .code_oe, .tone_valid_strobe, .strobe_clear_input,
		.oscillator_select, .crystal_input, .crystal_output, .atb_in,
		.atb_out, .atb_oe, .irq, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	line_monitor i_mon(.aclk, .aresetn, .en, .slow, .tone_valid_strobe,
		.code, .strobe_clear_input, .got, .pause_seen);
	initial
	begin
		aclk = 1'h0;
		forever #2 aclk = ~aclk;
	end
	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		total_checks++;
		if (s !== e)
		begin
			fail_count++;
			$display("Error %0t: saw %h want %h", $time, s, e);
		end
	endtask
	// a spent wait bound ends the run
	task automatic lim(input int k);
		if (k >= 4000)
		begin
			fail_count++;
			summarize;
		end
	endtask
	task automatic run(input int k);
		repeat (k) @(posedge aclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (n = 0; n < 4000; n++)
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid)
				break;
		end
		rs = s_axi_bresp;
		s_axi_bready <= 1'h0;
		lim(n);
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (n = 0; n < 4000; n++)
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid)
				break;
		end
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'h0;
		lim(n);
	endtask
	task automatic tone(input logic on, input logic [3:0] k, input int w);
		@(posedge aclk);
		key_index <= k;
		tone_pair <= on;
		run(w);
		#1;
	endtask
	initial
	begin
		{aresetn, tone_pair, key_index, slow, p, xp} = 0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
		{s_axi_arvalid, s_axi_rready, fail_count, total_checks} = 0;
		{oscillator_select, en} = 2'h3;
		run(8);
		aresetn <= 1'h1;
		rdr(`REG_CTRL);
		chk(rd, {30'h0, `CTRL_RESET});
		rdr(8'h20);
		chk({rs, rd}, {`RESP_SLVERR, 32'h0});
		wr(8'h20, 32'h1);
		chk(rs, `RESP_SLVERR);
		wr(`REG_INT_MASK, 32'h3);
		for (i = 0; i < 9; i++)
		begin
			wr(`REG_CTRL, {30'h0, 1'h1, rows[i][8]});
			tone(1'h1, rows[i][7:4], DC);
			chk(code, rows[i][3:0]);
			chk(tone_valid_strobe, 1'h0);
			for (n = 0; n < 4000 && !tone_valid_strobe; n++)
				@(posedge aclk);
			lim(n);
			chk(n > SD - 5 && n < SD + 5, 1'h1);
			run(50);
			#1;
			chk(got, rows[i][3:0]);
			chk({tone_valid_strobe, code}, rows[i][3:0]);
			tone(1'h0, 4'h0, DC + 2);
			chk({pause_seen, code}, 5'h10);
			$display("row %0d done", i);
		end
		rdr(`REG_INT_STAT);
		chk({irq, rd}, 33'h100000003);
		wr(`REG_INT_MASK, 32'h0);
		wr(`REG_INT_STAT, 32'h1);
		rdr(`REG_INT_STAT);
		chk({irq, rd}, 33'h2);
		wr(`REG_INT_MASK, 32'h2);
		run(2);
		chk(irq, 1'h1);
		wr(`REG_INT_STAT, 32'h2);
		wr(`REG_STATUS, 32'hFFFFFFFF);
		chk(rs, `RESP_OKAY);
		rdr(`REG_STATUS);
		chk({irq, rs, rd}, 35'h0);
		$display("registers done");
		en <= 1'h0;
		tone(1'h1, 4'h5, DC + SD + 100);
		chk({tone_valid_strobe, code}, 5'h15);
		en <= 1'h1;
		slow <= 1'h1;
		run(90);
		chk(tone_valid_strobe, 1'h1);
		run(20);
		chk({tone_valid_strobe, got}, 5'h05);
		tone(1'h0, 4'h0, DC + 2);
		chk(code, 4'h0);
		wr(`REG_CTRL, 32'h0);
		run(2);
		chk(code_oe, 1'h0);
		wr(`REG_CTRL, 32'h2);
		run(2);
		chk(code_oe, 1'h1);
		$display("hold and enable done");
		n = 0;
		q = 0;
		for (i = 0; i < 1024; i++)
		begin
			@(posedge aclk);
			n += (atb_out != p);
			q += (crystal_output != xp);
			p = atb_out;
			xp = crystal_output;
		end
		chk(n > 14 && n < 18 && atb_oe, 1'h1);
		chk(q > 100, 1'h1);
		oscillator_select <= 1'h0;
		rdr(`REG_TB_COUNT);
		r2 = rd;
		run(512);
		rdr(`REG_TB_COUNT);
		chk({atb_oe, atb_out, crystal_output, rd > r2}, 4'h1);
		$display("time base done");
		en <= 1'h0;
		tone(1'h1, 4'h7, DC + SD + 10);
		chk({tone_valid_strobe, code}, 5'h17);
		tone(1'h0, 4'h0, DC + 2);
		chk({tone_valid_strobe, pause_seen, code}, 6'h10);
		$display("pause under strobe done");
		tone(1'h1, 4'h7, DC);
		aresetn <= 1'h0;
		run(2);
		#1;
		chk({code, tone_valid_strobe, irq, code_oe, atb_oe}, 8'h0);
		aresetn <= 1'h1;
		rdr(`REG_CTRL);
		chk({code_oe, rd}, {1'h1, 30'h0, `CTRL_RESET});
		run(DC);
		chk(code, 4'h7);
		$display("reset done");
		summarize;
	end
endmodule
